// file: hw/pio_xbar_top.v
// port i/o block: registers, priority crossbar and 24 pin drivers
`timescale 1ns/1ps
`include "pio_map.vh"

// register map, one byte per address:
//   0x0-0x2 port latches; a read returns the live pin levels, not the latch
//   0x3-0x5 output mode, 1 = push-pull, 0 = open-drain
//   0x6-0x8 analog select, 1 = analog; such pins never drive and are skipped
//   0x9 first crossbar select: b0 uart, b1 spi, b2 smbus, b3 comparator,
//       b4 system clock out
//   0xA second crossbar select: b2:0 capture module count, b3 external count
//       clock, b6 crossbar on, b7 weak pull-up disable
//   other addresses read zero and drop writes
//
// function index is the priority, highest first:
//   0 uart tx
//   1 uart rx
//   2 spi clock
//   3 spi miso
//   4 spi mosi
//   5 spi slave select
//   6 smbus data
//   7 smbus clock
//   8 comparator out
//   9 system clock out
//   10-15 capture modules 0 to 5
//   16 external count clock
// each enabled function takes the next free digital pin; those left over
// find no pin and are not routed, and a capture count of 7 grants all six

// What this block does
// R1: 24 pins, three ports, digital or analog
// R2: enabled functions take pins by priority
// R3: port read returns live pin state
// R4: per-pin push-pull or open-drain mode bits
// R5: mode bits also govern crossbar peripheral pins
// R6: smbus data and clock always open-drain
// R7: pull-up disable low enables open-drain pull-ups
// R8: pull-up disable ignored on push-pull pins
// R9: pull-up off when driving low or analog
// R10: crossbar enable bit activates pin assignment
// R11: crossbar off: all pins plain inputs
// R12: crossbar off: every output driver disabled
// R13: software loads select registers before relying
// R14: unclaimed pins drive their latch bit
module pio_xbar_top (
  sys_clk,
  nrst,
  addr,
  wr_data,
  wr_en,
  rd_en,
  rd_data,
  pad_in,
  pad_out,
  pad_oe,
  pad_pu,
  fn_out,
  fn_drv,
  fn_in,
  xbar_on
);
  input wire sys_clk;
  input wire nrst;
  input wire [`PIO_ADDR_W-1:0] addr;
  input wire [`PIO_DATA_W-1:0] wr_data;
  input wire wr_en;
  input wire rd_en;
  output reg [`PIO_DATA_W-1:0] rd_data;
  input wire [`PIO_NPINS-1:0] pad_in;
  output reg [`PIO_NPINS-1:0] pad_out;
  output reg [`PIO_NPINS-1:0] pad_oe;
  output reg [`PIO_NPINS-1:0] pad_pu;
  input wire [`PIO_NFN-1:0] fn_out;
  input wire [`PIO_NFN-1:0] fn_drv;
  output reg [`PIO_NFN-1:0] fn_in;
  output reg xbar_on;

  reg [`PIO_NPINS-1:0] latch_q;
  reg [`PIO_NPINS-1:0] mode_q;
  reg [`PIO_NPINS-1:0] ana_q;
  reg [`PIO_DATA_W-1:0] xsel0_q;
  reg [`PIO_DATA_W-1:0] xsel1_q;
  reg [`PIO_DATA_W-1:0] rd_d;
  reg [`PIO_NFN-1:0] fn_en;
  reg [`PIO_NFN-1:0] fn_in_d;
  reg [2:0] cex_cnt;

  wire [`PIO_NPINS-1:0] pin_claim;
  wire [`PIO_NPINS*`PIO_FIDX_W-1:0] pin_fidx;
  wire [`PIO_NPINS-1:0] cell_out;
  wire [`PIO_NPINS-1:0] cell_oe;
  wire [`PIO_NPINS-1:0] cell_pu;
  wire xbar_en;
  wire weak_dis;
  wire [2:0] we_latch;
  wire [2:0] we_mode;
  wire [2:0] we_ana;
  wire we_xsel0;
  wire we_xsel1;

  integer k;
  integer q;
  integer r;

  function is_smbus;
    input [`PIO_FIDX_W-1:0] idx;
    begin
      is_smbus = (idx == `PIO_F_SDA) || (idx == `PIO_F_SCL);
    end
  endfunction

  // one-hot byte-lane decode for the three per-port register groups
  function [2:0] port_sel;
    input [`PIO_ADDR_W-1:0] a;
    input [`PIO_ADDR_W-1:0] base;
    begin
      port_sel[0] = (a == base);
      port_sel[1] = (a == base + 4'h1);
      port_sel[2] = (a == base + 4'h2);
    end
  endfunction

  // picks byte lane n of a per-pin vector
  function [7:0] byte_of;
    input [`PIO_NPINS-1:0] v;
    input [1:0] n;
    begin
      byte_of = v[n*8 +: 8];
    end
  endfunction

  assign xbar_en = xsel1_q[`PIO_X1_XBAR_EN]; // see R10
  // the pull-up disable is global; each pad cell decides its own pull-up
  assign weak_dis = xsel1_q[`PIO_X1_PU_DIS];

  // one write strobe per register
  assign we_latch = wr_en ? port_sel(addr, `PIO_A_LATCH0) : 3'h0;
  assign we_mode = wr_en ? port_sel(addr, `PIO_A_MODE0) : 3'h0;
  assign we_ana = wr_en ? port_sel(addr, `PIO_A_ANA0) : 3'h0;
  assign we_xsel0 = wr_en & (addr == `PIO_A_XSEL0);
  assign we_xsel1 = wr_en & (addr == `PIO_A_XSEL1);

  // per-port byte registers
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      latch_q <= {3{`PIO_RST_LATCH}};
      mode_q <= {3{`PIO_RST_MODE}};
      ana_q <= {3{`PIO_RST_ANA}};
    end
    else
    begin
      for (k = 0; k < 3; k = k + 1)
      begin
        if (we_latch[k])
          latch_q[k*8 +: 8] <= wr_data;
        if (we_mode[k])
          mode_q[k*8 +: 8] <= wr_data; // see R4
        if (we_ana[k])
          ana_q[k*8 +: 8] <= wr_data; // see R1
      end
    end
  end

  // crossbar selects; a new select takes effect on the pins one cycle later
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      xsel0_q <= `PIO_RST_XSEL;
      xsel1_q <= `PIO_RST_XSEL;
    end
    else
    begin
      if (we_xsel0)
        xsel0_q <= wr_data;
      if (we_xsel1)
        xsel1_q <= wr_data; // see R10
    end
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    case (addr)
      `PIO_A_LATCH0: rd_d = byte_of(pad_in, 2'h0); // see R3
      `PIO_A_LATCH1: rd_d = byte_of(pad_in, 2'h1); // see R3
      `PIO_A_LATCH2: rd_d = byte_of(pad_in, 2'h2); // see R3
      `PIO_A_MODE0: rd_d = mode_q[7:0];
      `PIO_A_MODE1: rd_d = mode_q[15:8];
      `PIO_A_MODE2: rd_d = mode_q[23:16];
      `PIO_A_ANA0: rd_d = ana_q[7:0];
      `PIO_A_ANA1: rd_d = ana_q[15:8];
      `PIO_A_ANA2: rd_d = ana_q[23:16];
      `PIO_A_XSEL0: rd_d = xsel0_q;
      `PIO_A_XSEL1: rd_d = xsel1_q;
      default: rd_d = 8'h00;
    endcase
  end

  // expand select fields into the priority-ordered function enables
  always @*
  begin
    cex_cnt = xsel1_q[`PIO_X1_CEX_HI:`PIO_X1_CEX_LO];
    fn_en = {`PIO_NFN{1'b0}};
    fn_en[`PIO_F_UTX] = xsel0_q[`PIO_X0_UART];
    fn_en[`PIO_F_URX] = xsel0_q[`PIO_X0_UART];
    fn_en[`PIO_F_SCK] = xsel0_q[`PIO_X0_SPI];
    fn_en[`PIO_F_MISO] = xsel0_q[`PIO_X0_SPI];
    fn_en[`PIO_F_MOSI] = xsel0_q[`PIO_X0_SPI];
    fn_en[`PIO_F_NSS] = xsel0_q[`PIO_X0_SPI];
    fn_en[`PIO_F_SDA] = xsel0_q[`PIO_X0_SMB];
    fn_en[`PIO_F_SCL] = xsel0_q[`PIO_X0_SMB];
    fn_en[`PIO_F_CMP] = xsel0_q[`PIO_X0_CMP];
    fn_en[`PIO_F_SYSCK] = xsel0_q[`PIO_X0_SYSCK];
    // capture modules are granted as a count, lowest numbered first
    for (q = 0; q < `PIO_NCEX; q = q + 1)
      fn_en[`PIO_F_CEX0 + q] = (q < cex_cnt);
    fn_en[`PIO_F_ECI] = xsel1_q[`PIO_X1_ECI];
  end

  pio_prio_dec u_dec (
    .fn_en(fn_en),
    .analog(ana_q),
    .pin_claim(pin_claim),
    .pin_fidx(pin_fidx)
  ); // see R2

  genvar g;
  generate
    for (g = 0; g < `PIO_NPINS; g = g + 1)
    begin : g_pin
      wire [`PIO_FIDX_W-1:0] idx;
      wire claim;
      assign idx = pin_fidx[g*`PIO_FIDX_W +: `PIO_FIDX_W];
      // claims only count once the crossbar is on
      assign claim = pin_claim[g] & xbar_en; // see R11
      pio_pad_cell u_cell (
        .xbar_en(xbar_en),
        .claimed(claim),
        .fn_val(fn_out[idx]),
        .fn_drv(fn_drv[idx]),
        .latch(latch_q[g]),
        .push_pull(mode_q[g]),
        .analog(ana_q[g]),
        .force_od(claim & is_smbus(idx)),
        .weak_dis(weak_dis),
        .out_val(cell_out[g]),
        .out_en(cell_oe[g]),
        .pu_en(cell_pu[g])
      );
    end
  endgenerate

  // route pin states back to the functions; an unrouted input idles high
  always @*
  begin
    fn_in_d = {`PIO_NFN{1'b1}};
    for (r = 0; r < `PIO_NPINS; r = r + 1)
    begin
      if (pin_claim[r] && xbar_en)
        fn_in_d[pin_fidx[r*`PIO_FIDX_W +: `PIO_FIDX_W]] = pad_in[r]; // see R11
    end
  end

  // bus answer stands one cycle after the strobe; zero otherwise so nothing lingers
  always @(posedge sys_clk)
  begin
    if (!nrst)
      rd_data <= 8'h00;
    else
      rd_data <= rd_en ? rd_d : 8'h00; // see R3
  end

  // pins leave from flops too: one cycle of lag on peripheral outputs buys
  // glitch-free pads, so pins move one cycle after a write
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      pad_out <= {`PIO_NPINS{1'b0}};
      pad_oe <= {`PIO_NPINS{1'b0}}; // see R12
      pad_pu <= {`PIO_NPINS{1'b0}};
      fn_in <= {`PIO_NFN{1'b1}};
      xbar_on <= 1'b0;
    end
    else
    begin
      pad_out <= cell_out;
      pad_oe <= cell_oe; // see R12
      pad_pu <= cell_pu; // see R7
      fn_in <= fn_in_d;
      xbar_on <= xbar_en; // see R10
    end
  end
endmodule

// file: hw/pio_map.vh
// register offsets, field positions, reset values and crossbar function indices
`ifndef PIO_MAP_VH
`define PIO_MAP_VH

`define PIO_ADDR_W 4
`define PIO_DATA_W 8
`define PIO_NPINS 24
`define PIO_NFN 17
`define PIO_FIDX_W 5

`define PIO_A_LATCH0 4'h0
`define PIO_A_LATCH1 4'h1
`define PIO_A_LATCH2 4'h2
`define PIO_A_MODE0 4'h3
`define PIO_A_MODE1 4'h4
`define PIO_A_MODE2 4'h5
`define PIO_A_ANA0 4'h6
`define PIO_A_ANA1 4'h7
`define PIO_A_ANA2 4'h8
`define PIO_A_XSEL0 4'h9
`define PIO_A_XSEL1 4'hA

`define PIO_RST_LATCH 8'hFF
`define PIO_RST_MODE 8'h00
`define PIO_RST_ANA 8'h00
`define PIO_RST_XSEL 8'h00

`define PIO_X0_UART 0
`define PIO_X0_SPI 1
`define PIO_X0_SMB 2
`define PIO_X0_CMP 3
`define PIO_X0_SYSCK 4
`define PIO_X1_CEX_LO 0
`define PIO_X1_CEX_HI 2
`define PIO_X1_ECI 3
`define PIO_X1_XBAR_EN 6
`define PIO_X1_PU_DIS 7

`define PIO_F_UTX 5'h00
`define PIO_F_URX 5'h01
`define PIO_F_SCK 5'h02
`define PIO_F_MISO 5'h03
`define PIO_F_MOSI 5'h04
`define PIO_F_NSS 5'h05
`define PIO_F_SDA 5'h06
`define PIO_F_SCL 5'h07
`define PIO_F_CMP 5'h08
`define PIO_F_SYSCK 5'h09
`define PIO_F_CEX0 5'h0A
`define PIO_F_ECI 5'h10
`define PIO_NCEX 6

`endif

// file: hw/pio_prio_dec.v
// priority decoder: hands enabled functions to the lowest free digital pins
`timescale 1ns/1ps
`include "pio_map.vh"

module pio_prio_dec (
  fn_en,
  analog,
  pin_claim,
  pin_fidx
);
  input wire [`PIO_NFN-1:0] fn_en;
  input wire [`PIO_NPINS-1:0] analog;
  output reg [`PIO_NPINS-1:0] pin_claim;
  output reg [`PIO_NPINS*`PIO_FIDX_W-1:0] pin_fidx;

  integer p;
  integer f;
  integer cur;
  integer pick;

  // function index order is the priority order; analog pins are passed over
  always @*
  begin
    pin_claim = {`PIO_NPINS{1'b0}};
    pin_fidx = {(`PIO_NPINS*`PIO_FIDX_W){1'b0}};
    cur = 0;
    for (p = 0; p < `PIO_NPINS; p = p + 1)
    begin
      pick = -1;
      if (!analog[p])
      begin
        for (f = `PIO_NFN - 1; f >= 0; f = f - 1)
        begin
          if (fn_en[f] && f >= cur)
            pick = f;
        end
      end
      if (pick >= 0)
      begin
        pin_claim[p] = 1'b1;
        pin_fidx[p*`PIO_FIDX_W +: `PIO_FIDX_W] = pick[`PIO_FIDX_W-1:0];
        cur = pick + 1;
      end
    end
  end
endmodule

// file: hw/pio_pad_cell.v
// one pin's output driver, drive type and weak pull-up decision
`timescale 1ns/1ps

module pio_pad_cell (
  xbar_en,
  claimed,
  fn_val,
  fn_drv,
  latch,
  push_pull,
  analog,
  force_od,
  weak_dis,
  out_val,
  out_en,
  pu_en
);
  input wire xbar_en;
  input wire claimed;
  input wire fn_val;
  input wire fn_drv;
  input wire latch;
  input wire push_pull;
  input wire analog;
  input wire force_od;
  input wire weak_dis;
  output reg out_val;
  output reg out_en;
  output reg pu_en;

  reg val;
  reg drv;
  reg pp;

  always @*
  begin
    val = claimed ? fn_val : latch; // see R14
    drv = claimed ? fn_drv : 1'b1;
    pp = push_pull & ~force_od; // see R5 see R6
    if (!xbar_en || analog)
    begin
      out_en = 1'b0; // see R11 see R12
      out_val = 1'b0;
    end
    else if (pp)
    begin
      out_en = drv;
      out_val = val;
    end
    else
    begin
      out_en = drv & ~val;
      out_val = 1'b0;
    end
    // pull-up only for open-drain, never while pulling low or on analog pins
    pu_en = ~weak_dis & ~pp & ~analog & ~out_en; // see R7 see R8 see R9
  end
endmodule

// file: testbench/pio_xbar_monitor.sv
// assertion checker for the port crossbar block
`timescale 1ns/1ps
`include "pio_map.vh"
module pio_xbar_monitor (
  input wire sys_clk,
  input wire nrst,
  input wire [`PIO_ADDR_W-1:0] addr,
  input wire [`PIO_DATA_W-1:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [`PIO_DATA_W-1:0] rd_data,
  input wire [`PIO_NPINS-1:0] pad_in,
  input wire [`PIO_NPINS-1:0] pad_oe,
  input wire [`PIO_NPINS-1:0] pad_pu,
  input wire [`PIO_NFN-1:0] fn_in,
  input wire xbar_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  off_no_drive_a: assert property (!xbar_on && !$past(xbar_on) |-> pad_oe == 0)
    else $error("driver enabled with crossbar off");
  off_fn_idle_a: assert property (!xbar_on && !$past(xbar_on) |-> &fn_in)
    else $error("function input routed with crossbar off");
  xbar_set_a: assert property (wr_en && addr == `PIO_A_XSEL1 && wr_data[`PIO_X1_XBAR_EN]
    |-> ##[1:2] xbar_on)
    else $error("crossbar did not come on");
  xbar_cause_a: assert property ($rose(xbar_on) |-> $past(wr_en) || $past(wr_en, 2))
    else $error("crossbar came on without a write");
  port_read_a: assert property (rd_en && addr == `PIO_A_LATCH0 |=> rd_data == $past(pad_in[7:0]))
    else $error("port read differs from pin state");
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 0)
    else $error("read data outside its cycle");
  pu_drive_a: assert property ((pad_pu & pad_oe) == 0)
    else $error("pull-up on while driving");
  rst_state_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    !nrst |=> pad_oe == 0 && !xbar_on)
    else $error("outputs not cleared by reset");
endmodule

bind pio_xbar_top pio_xbar_monitor mon (.sys_clk, .nrst, .addr, .wr_data, .wr_en, .rd_en,
  .rd_data, .pad_in, .pad_oe, .pad_pu, .fn_in, .xbar_on);

// file: testbench/pio_pin_model.sv
// board side of the pins: drivers, weak pull-ups and external sources
`timescale 1ns/1ps
`include "pio_map.vh"
module pio_pin_model (
  input wire sys_clk,
  input wire [`PIO_NPINS-1:0] pad_out,
  input wire [`PIO_NPINS-1:0] pad_oe,
  input wire [`PIO_NPINS-1:0] pad_pu,
  input wire [`PIO_NPINS-1:0] ext_en,
  input wire [`PIO_NPINS-1:0] ext_val,
  output logic [`PIO_NPINS-1:0] pad_lvl
);
  logic [`PIO_NPINS-1:0] float_q = 24'h000000;
  // a floating pin wanders every cycle so no stale level can pass for a real one
  always @(posedge sys_clk)
    float_q <= ~float_q;
  always_comb
    pad_lvl = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
      | (~pad_oe & ~ext_en & (pad_pu | float_q));
endmodule

// file: testbench/pio_xbar_top_tb.sv
// self-checking bench for the port crossbar block
`timescale 1ns/1ps
module pio_xbar_top_tb;
  logic sys_clk = 1'h0, nrst = 1'h0, wr_en = 1'h0, rd_en = 1'h0, xbar_on;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h00, rd_data, rd_q;
  logic [23:0] pad_in, pad_out, pad_oe, pad_pu, ext_en = 24'h000000, ext_val = 24'h000000;
  logic [16:0] fn_out = 17'h00000, fn_drv = 17'h00000, fn_in;
  int miscompares = 0, checks = 0, cycles = 0;
  initial forever #4 sys_clk = ~sys_clk;
  pio_xbar_top uut (.sys_clk, .nrst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .pad_in,
    .pad_out, .pad_oe, .pad_pu, .fn_out, .fn_drv, .fn_in, .xbar_on);
  pio_pin_model pins (.sys_clk, .pad_out, .pad_oe, .pad_pu, .ext_en, .ext_val,
    .pad_lvl(pad_in));
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge sys_clk);
    wr_en <= 1'h0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge sys_clk);
    rd_en <= 1'h0;
    #1 rd_q = rd_data;
  endtask
  // pins pass through the board model and back in, so allow a few edges
  task settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task t_regs;
    settle;
    chk(pad_pu, 24'hFFFFFF);
    chk(xbar_on, 1'h0);
    for (int a = 3; a < 11; a++)
    begin
      rd(a[3:0]);
      chk(rd_q, 8'h00);
    end
    wr(4'h4, 8'h5A);
    rd(4'h4);
    chk(rd_q, 8'h5A);
    wr(4'hF, 8'h77);
    rd(4'hF);
    chk(rd_q, 8'h00);
    ext_en <= 24'hFF0000;
    ext_val <= 24'hA50000;
    settle;
    rd(4'h2);
    chk(rd_q, 8'hA5);
    chk(pad_oe, 24'h000000);
    chk(fn_in, 17'h1FFFF);
    ext_en <= 24'h000000;
    wr(4'h4, 8'h00);
    $display("register test done");
  endtask
  task t_gpio;
    wr(4'h0, 8'h0F);
    wr(4'h3, 8'hFF);
    settle;
    chk(pad_oe, 24'h000000);
    wr(4'hA, 8'h40);
    wr(4'h3, 8'h00);
    settle;
    chk(pad_oe, 24'h0000F0);
    chk(xbar_on, 1'h1);
    chk(pad_out[7:0], 8'h00);
    chk(pad_pu, 24'hFFFF0F);
    rd(4'h0);
    chk(rd_q, 8'h0F);
    wr(4'h3, 8'hFF);
    settle;
    chk(pad_oe, 24'h0000FF);
    chk(pad_out[7:0], 8'h0F);
    chk(pad_pu, 24'hFFFF00);
    wr(4'hA, 8'hC0);
    settle;
    chk(pad_pu, 24'h000000);
    $display("port test done");
  endtask
  task t_prio;
    wr(4'hA, 8'h40);
    wr(4'h0, 8'hFF);
    wr(4'h9, 8'h05);
    fn_drv <= 17'h000C1;
    fn_out <= 17'h00041;
    ext_en <= 24'h000002;
    settle;
    chk(pad_oe[7:0], 8'hF9);
    chk(pad_out[7:0], 8'hF1);
    chk(pad_pu[7:0], 8'h04);
    chk(fn_in[1], 1'h0);
    ext_en <= 24'h000004;
    wr(4'h6, 8'h01);
    settle;
    chk(pad_oe[7:0], 8'hF2);
    chk(pad_pu[7:0], 8'h08);
    chk(fn_in[1], 1'h0);
    // spi, comparator, clock out, three capture modules and the count clock
    wr(4'h6, 8'h00);
    wr(4'h9, 8'h1A);
    wr(4'hA, 8'h4B);
    fn_drv <= 17'h00400;
    fn_out <= 17'h00000;
    ext_en <= 24'h000200;
    settle;
    chk(pad_oe, 24'h000040);
    chk(fn_in[16], 1'h0);
    chk(fn_in[15:13], 3'h7);
    $display("priority test done");
  endtask
  task give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'h1;
    t_regs;
    t_gpio;
    t_prio;
    give_verdict;
  end
endmodule
